//--- shared/wwdc_pkg.sv
// Package for the windowed watchdog control block: register map, fields,
// reset values and timing constants.
// Assumes a Wishbone classic slave with 32-bit data, one register per word.
package wwdc_pkg;
  // Register byte addresses.
  localparam logic [7:0] ADDR_PERIOD_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CLOCK_WINDOW_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PRESCALE_LOW = 8'h08;
  localparam logic [7:0] ADDR_PRESCALE_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_COUNT_STATE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_CLEAR_CMD = 8'h1C;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h20;
  // Field positions.
  localparam int CS_LSB = 4;
  localparam int WIN_LSB = 0;
  localparam int PS_LSB = 1;
  localparam int ON_BIT = 0;
  localparam int TMR_LSB = 3;
  localparam int ARMED_BIT = 2;
  // Configuration codes and reset values.
  localparam logic [2:0] CS_UNLOCKED = 3'h7;
  localparam logic [2:0] CS_LFOSC = 3'h0;
  localparam logic [2:0] CS_MFOSC = 3'h1;
  localparam logic [2:0] WIN_UNLOCKED = 3'h7;
  localparam logic [4:0] PS_UNLOCKED = 5'h1F;
  localparam logic [4:0] PS_DEFAULT = 5'h0B;
  localparam logic [4:0] PS_MAX_LEGAL = 5'h12;
  localparam logic [31:0] CLEAR_KEY = 32'h0000_00A5;
  // Timing: system clock and the two oscillator rates.
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int LFOSC_HZ = 31_000;
  localparam int MFOSC_HZ = 31_250;
  localparam int LF_DIV = SYS_CLK_HZ / LFOSC_HZ;
  localparam int MF_DIV = SYS_CLK_HZ / MFOSC_HZ;
  // Base prescale for code 0 is 2^5 ticks.
  localparam int PS_BASE_LOG2 = 5;
  // Interrupt status bits.
  localparam int IRQ_VIOL = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_CLEARED = 2;

  typedef struct packed {
    logic [2:0] clock_select;
    logic [2:0] open_fraction;
    logic [4:0] period_select;
    logic [1:0] watchdog_mode;
  } wwdc_cfg_t;

  typedef struct packed {
    logic [17:0] prescale_count;
    logic [4:0] timer_count;
    logic armed;
  } wwdc_view_t;
endpackage

//--- logic/wwdc_tick.sv
// Tick divider: one-cycle enable at the selected watchdog oscillator rate.
// Assumes sys_clk at 40 MHz; reserved selects fall back to the slow rate.
`timescale 1ns/1ps
`default_nettype none
module wwdc_tick
  import wwdc_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [2:0] clock_select, // Runtime clock select.
  output logic tick // One-cycle watchdog tick.
);
  localparam logic [10:0] LF_LAST = 11'(LF_DIV - 1);
  localparam logic [10:0] MF_LAST = 11'(MF_DIV - 1);
  logic [10:0] div_q;
  logic [10:0] last;

  assign last = (clock_select == CS_MFOSC) ? MF_LAST : LF_LAST;

  // Divider restarts on each tick, so a select change takes effect at once.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 11'h000;
      tick <= 1'b0;
    end else if (div_q >= last) begin
      div_q <= 11'h000;
      tick <= 1'b1;
    end else begin
      div_q <= div_q + 11'h001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- logic/wwdc_top.sv
// Windowed watchdog control: runtime registers, window check and counters.
// Assumes a Wishbone classic master and static configuration-word inputs.
// The reset request is one cycle wide; the system side must stretch it.
// Operation
// - Clock source 000 selects slow oscillator, 001 medium; others reserved.
// - Window code n opens the last (n+1)/8 of each period.
// - Clock select resets to 000 if config is 111, else config value.
// - Window field resets to the configuration window value.
// - Clock select is read-only unless config clock select is 111.
// - Window field is read-only unless config window is 111.
// - The 18-bit prescale count is visible read-only to software.
// - Prescale bits split low byte, high byte, count register bits 1-0.
// - Five-bit timer count reads in count register bits 7-3.
// - Count register bit 2 shows the armed state.
// - Prescale and count registers are read-only and zero after reset.
// - Clock/window register bits 7 and 3 read zero, ignore writes.
// - Period select resets from config, or 01011 if config 11111.
// - Period select picks a power-of-two division of the oscillator.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wwdc_top
  import wwdc_pkg::*;
(
  input wire logic sys_clk, // System clock, 40 MHz.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire wwdc_cfg_t cfg, // Configuration word fields, static.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  output logic irq, // Level interrupt.
  output logic sys_reset_req // One-cycle system reset request.
);
  // Runtime register fields.
  logic [2:0] cs_q;
  logic [2:0] win_q;
  logic [4:0] ps_q;
  logic on_q;

  // Counters, status and cause flags.
  logic [17:0] pre_q;
  logic [4:0] tmr_q;
  logic armed_q;
  logic [2:0] sts_q;
  logic [2:0] msk_q;
  logic viol_flag_q;
  logic wdt_flag_q;
  logic init_q;

  // Tick, enable and bus decode.
  logic tick;
  logic enabled;
  logic req;
  logic wr;
  logic rd;
  logic wr_lo;
  logic cause_wr;
  logic sts_wr;
  logic clear_req;

  // Window arithmetic and events.
  logic win_open;
  logic timeout;
  logic viol_ev;
  logic tmo_ev;
  logic good_clear;
  logic [4:0] ps_eff;
  logic [23:0] period_ticks;
  logic [22:0] elapsed;
  logic [23:0] open_ticks;
  logic [26:0] open_prod;
  logic [31:0] rdata;
  logic [2:0] ev;

  // Watchdog tick at the rate of the selected oscillator.
  wwdc_tick u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clock_select(cs_q),
    .tick(tick)
  );

  // A new request is one not yet acknowledged; ack comes one edge later.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd = req && !wb_we_i;
  // Writes land at the edge where the master samples ack high, so a
  // master that abandons a cycle before ack never leaves a half write.
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wr_lo = wr && wb_sel_i[0];
  // Byte lane 0 carries every field; the other lanes are ignored except by the full-word clear command.
  assign cause_wr = wr_lo && (wb_adr_i == ADDR_RESET_CAUSE);
  assign sts_wr = wr_lo && (wb_adr_i == ADDR_IRQ_STATUS);

  // Mode 01 follows the software bit, 1x always on, 00 off.
  // The mode is a configuration strap, so software cannot stop mode 1x.
  assign enabled = cfg.watchdog_mode[1] || (cfg.watchdog_mode[0] && on_q);

  // Strap capture one edge after reset release keeps async reset constant.
  // Software must therefore wait one edge after release before access.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Clock select: reset load, then writable only when unlocked.
  // A reserved code is kept as written and runs from the slow rate.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q <= CS_LFOSC;
    end else if (init_q) begin
      cs_q <= (cfg.clock_select == CS_UNLOCKED) ? CS_LFOSC : cfg.clock_select;
    end else if (wr_lo && wb_adr_i == ADDR_CLOCK_WINDOW_CTRL &&
                 cfg.clock_select == CS_UNLOCKED) begin
      cs_q <= wb_dat_i[CS_LSB +: 3];
    end
  end

  // Window field: reset load, then writable only when unlocked.
  // Code 111 leaves the window open for the whole period.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= WIN_UNLOCKED;
    end else if (init_q) begin
      win_q <= cfg.open_fraction;
    end else if (wr_lo && wb_adr_i == ADDR_CLOCK_WINDOW_CTRL &&
                 cfg.open_fraction == WIN_UNLOCKED) begin
      win_q <= wb_dat_i[WIN_LSB +: 3];
    end
  end

  // Period select: reset load, then writable only when unlocked.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ps_q <= PS_DEFAULT;
    end else if (init_q) begin
      ps_q <= (cfg.period_select == PS_UNLOCKED) ? PS_DEFAULT
                                                 : cfg.period_select;
    end else if (wr_lo && wb_adr_i == ADDR_PERIOD_CTRL &&
                 cfg.period_select == PS_UNLOCKED) begin
      ps_q <= wb_dat_i[PS_LSB +: 5];
    end
  end

  // Software enable; it only matters when the mode defers to software.
  // Every reset stops a software-started watchdog until it is set again.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_q <= 1'b0;
    end else if (wr_lo && wb_adr_i == ADDR_PERIOD_CTRL) begin
      on_q <= wb_dat_i[ON_BIT];
    end
  end

  // power-of-two period
  // Reserved codes above the largest legal one give the shortest interval.
  assign ps_eff = (ps_q > PS_MAX_LEGAL) ? 5'h00 : ps_q;
  // The longest code needs 2^23 ticks, one bit more than the count holds.
  assign period_ticks = 24'h00_0001 << (5'(PS_BASE_LOG2) + ps_eff);
  assign elapsed = {tmr_q, pre_q};

  // window open fraction
  // Open once elapsed reaches the closed (7-n)/8 share of the period.
  assign open_prod = {3'h0, period_ticks} * {24'h00_0000, 3'h7 - win_q};
  assign open_ticks = open_prod[26:3];
  assign win_open = (win_q == WIN_UNLOCKED) ||
                    ({1'b0, elapsed} >= open_ticks);
  // Expiry on the tick that would make elapsed reach the full period.
  assign timeout = tick && ({1'b0, elapsed} + 24'h00_0001 >= period_ticks);

  // Clear command needs a key so stray writes do not count as clears.
  // Only a full-word write counts; a partial write never clears.
  assign clear_req = wr && wb_sel_i == 4'hF && wb_adr_i == ADDR_CLEAR_CMD &&
                     wb_dat_i == CLEAR_KEY && enabled;

  // Count chain: 18-bit prescaler feeding the 5-bit timer count.
  // A stopped watchdog holds both at zero so a restart is a full period.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_q <= 18'h0_0000;
      tmr_q <= 5'h00;
    end else if (!enabled || clear_req || timeout) begin
      pre_q <= 18'h0_0000;
      tmr_q <= 5'h00;
    end else if (tick) begin
      {tmr_q, pre_q} <= elapsed + 23'h00_0001;
    end
  end

  // armed follows enable
  // Armed follows the enable one clock later rather than waiting for a tick.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed_q <= 1'b0;
    end else begin
      armed_q <= enabled;
    end
  end

  // timeout reset
  // One pulse per violation or expiry; ticks are far apart, so no merge.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_reset_req <= 1'b0;
    end else begin
      sys_reset_req <= viol_ev || tmo_ev;
    end
  end

  // violation flag
  // Flags are set by hardware and cleared by writing ones; set wins.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      viol_flag_q <= 1'b0;
    end else if (viol_ev) begin
      viol_flag_q <= 1'b1;
    end else if (cause_wr && wb_dat_i[IRQ_VIOL]) begin
      viol_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_flag_q <= 1'b0;
    end else if (tmo_ev) begin
      wdt_flag_q <= 1'b1;
    end else if (cause_wr && wb_dat_i[IRQ_TIMEOUT]) begin
      wdt_flag_q <= 1'b0;
    end
  end

  // Outcome of a clear and of expiry, shared by flags and interrupts.
  assign viol_ev = clear_req && !win_open;
  assign good_clear = clear_req && win_open;
  assign tmo_ev = enabled && timeout;

  // Interrupt events: violation, timeout and a good clear.
  assign ev[IRQ_VIOL] = viol_ev;
  assign ev[IRQ_TIMEOUT] = tmo_ev;
  assign ev[IRQ_CLEARED] = good_clear;

  // Sticky status, one flop per event; an event in the clearing cycle
  // wins over the clear so that no event is ever lost.
  for (genvar gi = 0; gi < 3; gi++) begin : g_sts
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        sts_q[gi] <= 1'b0;
      end else if (ev[gi]) begin
        sts_q[gi] <= 1'b1;
      end else if (sts_wr && wb_dat_i[gi]) begin
        sts_q[gi] <= 1'b0;
      end
    end
  end

  // Interrupt mask, same layout as the status register.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      msk_q <= 3'h0;
    end else if (wr_lo && wb_adr_i == ADDR_IRQ_MASK) begin
      msk_q <= wb_dat_i[2:0];
    end
  end

  // Interrupt output registered so it comes straight from a flop.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |((sts_q | ev) & msk_q);
    end
  end

  // Read multiplexer; unmapped addresses read zero.
  // Reads have no side effects, so a debug read never disturbs a count.
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_PERIOD_CTRL: begin
        rdata[PS_LSB +: 5] = ps_q;
        rdata[ON_BIT] = on_q;
      end
      ADDR_CLOCK_WINDOW_CTRL: begin
        rdata[CS_LSB +: 3] = cs_q;
        rdata[WIN_LSB +: 3] = win_q;
      end
      ADDR_PRESCALE_LOW: rdata[7:0] = pre_q[7:0];
      ADDR_PRESCALE_HIGH: rdata[7:0] = pre_q[15:8];
      ADDR_COUNT_STATE: begin
        rdata[TMR_LSB +: 5] = tmr_q;
        rdata[ARMED_BIT] = armed_q;
        rdata[1:0] = pre_q[17:16];
      end
      ADDR_IRQ_STATUS: rdata[2:0] = sts_q;
      ADDR_IRQ_MASK: rdata[2:0] = msk_q;
      ADDR_RESET_CAUSE: rdata[1:0] = {wdt_flag_q, viol_flag_q};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // One-wait-state acknowledge: exactly one cycle after the request edge.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data is registered with ack and zero at all other times, so a
  // stale value never sits on the bus between cycles.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd ? rdata : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

//--- testbench/wwdc_properties.sv
// Assertion checker for the watchdog control block ports.
// Assumes the bus master keeps the classic cycle rules.
`timescale 1ns/1ps
`default_nettype none
module wwdc_properties
  import wwdc_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic reset_n, // Reset.
  input wire wwdc_cfg_t cfg, // Config.
  input wire logic wb_cyc_i, // Cycle.
  input wire logic wb_stb_i, // Strobe.
  input wire logic wb_we_i, // Write.
  input wire logic [7:0] wb_adr_i, // Address.
  input wire logic [3:0] wb_sel_i, // Selects.
  input wire logic [31:0] wb_dat_i, // Data in.
  input wire logic [31:0] wb_dat_o, // Data out.
  input wire logic wb_ack_o, // Ack.
  input wire logic irq, // Interrupt.
  input wire logic sys_reset_req // Reset request.
);
  logic rd;
  // Read data only counts in the acknowledge cycle.
  assign rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_ACK_ONE: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing wrong");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("data outside ack");
  AST_CWC_RSVD: assert property (
    rd && wb_adr_i == ADDR_CLOCK_WINDOW_CTRL
    |-> wb_dat_o[31:7] == '0 && !wb_dat_o[3])
    else $error("unused bits set");
  AST_CS_LOCK: assert property (
    rd && wb_adr_i == ADDR_CLOCK_WINDOW_CTRL && cfg.clock_select != 3'h7
    |-> wb_dat_o[6:4] == cfg.clock_select)
    else $error("clock select moved");
  AST_WIN_LOCK: assert property (
    rd && wb_adr_i == ADDR_CLOCK_WINDOW_CTRL && cfg.open_fraction != 3'h7
    |-> wb_dat_o[2:0] == cfg.open_fraction)
    else $error("window moved");
  AST_PS_LOCK: assert property (
    rd && wb_adr_i == ADDR_PERIOD_CTRL && cfg.period_select != 5'h1F
    |-> wb_dat_o[5:1] == cfg.period_select)
    else $error("period select moved");
  AST_OFF_ZERO: assert property (
    rd && wb_adr_i inside {[8'h08:8'h10]} && cfg.watchdog_mode == 2'h0
    |-> wb_dat_o == '0)
    else $error("counts not zero");
  AST_ARMED: assert property (
    rd && wb_adr_i == ADDR_COUNT_STATE && cfg.watchdog_mode[1]
    |-> wb_dat_o[ARMED_BIT])
    else $error("armed bit low");
  AST_RO_UPPER: assert property (
    rd && wb_adr_i inside {[8'h08:8'h10]} |-> wb_dat_o[31:8] == '0)
    else $error("count upper bits set");
  AST_REQ_PULSE: assert property (sys_reset_req |=> !sys_reset_req)
    else $error("reset request too long");
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the watchdog control block.
// Drives Wishbone and the configuration word; no partner model.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import wwdc_pkg::*;
;
  logic sys_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0;
  logic ack, irq, rreq;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
  wwdc_cfg_t cfg = '0;
  int n_fail = 0, checked = 0, n_req = 0, since = 0, t_req = 0, nr;

  always #12.5 sys_clk = ~sys_clk;

  wwdc_top u_wwdc_top (.sys_clk(sys_clk), .reset_n(reset_n), .cfg(cfg),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .irq(irq), .sys_reset_req(rreq));

  // Time each reset request from the last reset release.
  always @(posedge sys_clk) begin
    since <= reset_n ? since + 1 : 0;
    if (rreq === 1'b1) begin
      n_req <= n_req + 1;
      t_req <= since;
    end
  end

  task automatic complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; the wait is bounded in case ack never comes.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    chk(ack, 1);
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask

  task automatic restart(input wwdc_cfg_t c);
    @(posedge sys_clk);
    reset_n <= 0;
    cfg <= c;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1;
    @(posedge sys_clk);
  endtask

  task automatic wait_req(input int lim);
    int c;
    c = 0;
    nr = n_req;
    while (n_req == nr && c < lim) begin
      @(posedge sys_clk);
      c++;
    end
    repeat (2) @(posedge sys_clk);
  endtask

  // Long enough for both timeout runs plus the register tests.
  initial begin
    #2_600_000;
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    // Locked fields and a stopped watchdog.
    restart({3'h1, 3'h2, 5'h04, 2'h0});
    rdc(ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0012);
    wb(1, ADDR_CLOCK_WINDOW_CTRL, 32'h0000_00FF);
    rdc(ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0012);
    rdc(ADDR_PERIOD_CTRL, 32'h0000_0008);
    wb(1, ADDR_PRESCALE_LOW, 32'h0000_00FF);
    for (int a = 8; a <= 16; a += 4)
      rdc(8'(a), 32'h0000_0000);
    rdc(8'h30, 32'h0000_0000);
    // Software-enabled mode: armed only once the enable bit is set.
    restart({3'h0, 3'h7, 5'h00, 2'h1});
    rdc(ADDR_COUNT_STATE, 32'h0000_0000);
    wb(1, ADDR_PERIOD_CTRL, 32'h0000_0001);
    rdc(ADDR_PERIOD_CTRL, 32'h0000_0001);
    rdc(ADDR_COUNT_STATE, 32'h0000_0004);
    // Unlocked fields, always on, slow oscillator timeout.
    restart({3'h7, 3'h7, 5'h1F, 2'h2});
    rdc(ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0007);
    rdc(ADDR_PERIOD_CTRL, 32'h0000_0016);
    wb(1, ADDR_PERIOD_CTRL, 32'h0000_0000);
    wb(1, ADDR_IRQ_MASK, 32'h0000_0003);
    wait_req(45000);
    chk(32'(t_req > 32 * LF_DIV - 40 && t_req < 32 * LF_DIV + 40), 1);
    chk(irq, 1);
    rdc(ADDR_RESET_CAUSE, 32'h0000_0002);
    wb(1, ADDR_IRQ_STATUS, 32'h0000_0002);
    wb(1, ADDR_RESET_CAUSE, 32'h0000_0003);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0000);
    chk(irq, 0);
    wb(1, ADDR_CLOCK_WINDOW_CTRL, 32'h0000_00FF);
    rdc(ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0077);
    wb(1, ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0007);
    // A clear in a fully open window is accepted.
    wb(1, ADDR_CLEAR_CMD, CLEAR_KEY);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0004);
    chk(irq, 0);
    chk(n_req, nr + 1);
    repeat (3 * LF_DIV + 10) @(posedge sys_clk);
    rdc(ADDR_COUNT_STATE, 32'h0000_0004);
    wb(0, ADDR_PRESCALE_LOW, 32'h0000_0000);
    chk(32'(rdat >= 2 && rdat <= 4), 1);
    // A clear in a closed window is a violation.
    wb(1, ADDR_CLOCK_WINDOW_CTRL, 32'h0000_0000);
    wb(1, ADDR_CLEAR_CMD, CLEAR_KEY);
    wait_req(20);
    chk(n_req, nr + 1);
    rdc(ADDR_RESET_CAUSE, 32'h0000_0001);
    rdc(ADDR_IRQ_STATUS, 32'h0000_0005);
    chk(irq, 1);
    // Locked medium oscillator; a reserved period code acts as 1:32.
    restart({3'h1, 3'h7, 5'h13, 2'h2});
    wait_req(45000);
    chk(32'(t_req > 32 * MF_DIV - 40 && t_req < 32 * MF_DIV + 40), 1);
    complete_run();
  end
endmodule

bind wwdc_top wwdc_properties u_wwdc_properties (.sys_clk(sys_clk),
  .reset_n(reset_n), .cfg(cfg), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq(irq), .sys_reset_req(sys_reset_req));
`default_nettype wire
